// ### src/vdp_pkg.sv
// Purpose: Shared constants, types and helpers for the valve driver pair SPI messages
// Assumes: 16-bit frames, most significant bit first, SPI mode 0
// Notes:   Both link ends and the host register map use these names
package vdp_pkg;

  localparam int          FRAME_BITS   = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  FRAME_CNT    = 5'h10;

  // Frame field positions
  localparam int          POS_PARITY   = 15;
  localparam int          POS_FMSG     = 14;
  localparam int          POS_OC       = 13;
  localparam int          POS_OL       = 12;
  localparam int          POS_OT       = 11;
  localparam int          POS_VDS      = 10;
  localparam int          SEL_HI       = 14;
  localparam int          SEL_LO       = 10;
  localparam int          PAY_HI       = 9;
  localparam int          DUTY_LO      = 2;

  // Message selector codes
  localparam logic [4:0]  MSG_DRV_THREE = 5'h0C;
  localparam logic [4:0]  MSG_DRV_FOUR  = 5'h0D;

  // Odd parity: bit 15 makes the count of ones over bits 15..0 odd
  localparam logic        PARITY_ODD   = 1'b1;

  // Host register map (word index on the host's plain port)
  localparam logic [3:0]  REG_TX       = 4'h0;
  localparam logic [3:0]  REG_RX       = 4'h1;
  localparam logic [3:0]  REG_STATUS   = 4'h2;
  localparam logic [3:0]  REG_CTRL     = 4'h3;
  localparam logic [3:0]  REG_INTSTAT  = 4'h4;
  localparam logic [3:0]  REG_INTMASK  = 4'h5;

  // Interrupt / status / control bit positions
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_FMSG     = 1;
  localparam int          IRQ_FAULT    = 2;
  localparam int          IRQ_BADRESP  = 3;
  localparam int          IRQ_W        = 4;
  localparam int          ST_BUSY      = 0;
  localparam int          CTRL_BADPAR  = 0;

  typedef enum logic [1:0] {SEL_NONE, SEL_THREE, SEL_FOUR} vdp_sel_e;

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_GAP} vdp_hstate_e;

  function automatic logic vdp_parity(input logic [14:0] d);
    return PARITY_ODD ? ~(^d) : (^d);
  endfunction : vdp_parity

  function automatic vdp_sel_e vdp_decode(input logic [4:0] id);
    if (id == MSG_DRV_THREE) begin
      return SEL_THREE;
    end else if (id == MSG_DRV_FOUR) begin
      return SEL_FOUR;
    end
    return SEL_NONE;
  endfunction : vdp_decode

endpackage : vdp_pkg

// ### src/vdp_spi_if.sv
// Purpose: SPI link between the host controller and the valve driver pair
// Assumes: Host drives the clock, select and data out; device drives its data out
// Notes:   The returned data line idles high while the device does not drive it
`timescale 1ns/1ns
`default_nettype none
interface vdp_spi_if;
  logic sck;      // Link clock from host
  logic csN;      // Frame select, active low
  logic mosi;     // Host to device data
  logic miso;     // Device to host data
  logic misoOe;   // Device drives miso
  logic misoLine; // Resolved level seen by the host

  assign misoLine = misoOe ? miso : 1'b1;

  modport device (input sck, input csN, input mosi, output miso, output misoOe);
  modport host   (output sck, output csN, output mosi, input misoLine);
endinterface : vdp_spi_if
`default_nettype wire

// ### src/vdp_device_end.sv
// Purpose: Device end of the valve driver three/four SPI messages
// Assumes: Link pins asynchronous to clk_sys, sampled through two flip-flops
// Notes:   The reply in frame N answers the message of frame N-1
// Function
// - Selector 01100 addresses valve driver three
// - Selector 01101 addresses valve driver four
// - Bits 9..0 carry set point or duty
// - Regulation on: 10-bit current target taken
// - Host keeps duty at 0, 100, 10..90%
// - Duty mode: bits 9..2 used, 1..0 ignored
// - Parity checked, read bit 14 zero if valid
// - Read bit 14 set on bad parity
// - Read bit 13 reports overcurrent shutdown
// - Read bit 12 reports open load
// - Read bit 11 reports overtemperature shutdown
// - Read bit 10 drain voltage, information only
// - Regulation on, source 0: return target
// - Regulation on, source 1: return applied duty
// - Regulation off, source 0: duty, low bits 00
// - Regulation off, source 1: measured current
`timescale 1ns/1ns
`default_nettype none
module vdp_device_end
  import vdp_pkg::*;
(
  input  wire logic        clk_sys,                     // System clock
  input  wire logic        rst_n,                       // Sync reset, active low
  vdp_spi_if.device        spi,                         // SPI link
  input  wire logic        pairBRegulationOff,          // 1: duty-cycle mode
  input  wire logic        readbackSourceSelect,        // Readback source
  input  wire logic        drvThreeOvercurrent,         // Driver 3 overcurrent shutdown
  input  wire logic        drvThreeOpenLoad,            // Driver 3 open load
  input  wire logic        drvThreeOvertemp,            // Driver 3 overtemp shutdown
  input  wire logic        drvThreeDrainVoltageSeen,    // Driver 3 drain voltage flag
  input  wire logic        drvFourOvercurrent,          // Driver 4 overcurrent shutdown
  input  wire logic        drvFourOpenLoad,             // Driver 4 open load
  input  wire logic        drvFourOvertemp,             // Driver 4 overtemp shutdown
  input  wire logic        drvFourDrainVoltageSeen,     // Driver 4 drain voltage flag
  input  wire logic [7:0]  drvThreeAppliedDuty,         // Driver 3 regulator duty
  input  wire logic [7:0]  drvFourAppliedDuty,          // Driver 4 regulator duty
  input  wire logic [9:0]  drvThreeMeasuredCurrent,     // Driver 3 measured current
  input  wire logic [9:0]  drvFourMeasuredCurrent,      // Driver 4 measured current
  output logic      [9:0]  drvThreeCurrentTarget,       // Driver 3 current target
  output logic      [9:0]  drvFourCurrentTarget,        // Driver 4 current target
  output logic      [7:0]  drvThreeDuty,                // Driver 3 programmed duty
  output logic      [7:0]  drvFourDuty,                 // Driver 4 programmed duty
  output logic             drvThreeUpdate,              // Pulse: driver 3 written
  output logic             drvFourUpdate,               // Pulse: driver 4 written
  output logic             parityErrorSeen              // Last frame was bad
);

  typedef struct packed {
    logic [1:0]             sckSync;
    logic [1:0]             csSync;
    logic [1:0]             mosiSync;
    logic                   sckPrev;
    logic                   csPrev;
    logic [FRAME_BITS-1:0]  rxShift;
    logic [FRAME_BITS-1:0]  txShift;
    logic [CNT_W-1:0]       bitCnt;
    logic                   parityError;
    vdp_sel_e               lastSel;
    logic [1:0][9:0]        target;
    logic [1:0][7:0]        duty;
    logic [1:0]             update;
  } vdp_dev_s;

  vdp_dev_s st;
  vdp_dev_s next_st;

  logic [1:0][3:0]  faults;
  logic [1:0][7:0]  appliedDuty;
  logic [1:0][9:0]  measured;
  logic             sckRise;
  logic             sckFall;
  logic             csFall;
  logic             csRise;
  logic             frameOk;
  logic             replyIdx;
  logic [9:0]       replyPayload;
  logic [14:0]      replyBody;
  vdp_sel_e         rxSel;
  logic             rxIdx;

  // Flags ordered oc, open load, overtemp, drain voltage to match bits 13..10
  assign faults[0]      = {drvThreeOvercurrent, drvThreeOpenLoad,
                           drvThreeOvertemp, drvThreeDrainVoltageSeen};
  assign faults[1]      = {drvFourOvercurrent, drvFourOpenLoad,
                           drvFourOvertemp, drvFourDrainVoltageSeen};
  assign appliedDuty[0] = drvThreeAppliedDuty;
  assign appliedDuty[1] = drvFourAppliedDuty;
  assign measured[0]    = drvThreeMeasuredCurrent;
  assign measured[1]    = drvFourMeasuredCurrent;

  always_comb begin
    next_st      = st;
    sckRise      = st.sckSync[1] & ~st.sckPrev;
    sckFall      = ~st.sckSync[1] & st.sckPrev;
    csFall       = ~st.csSync[1] & st.csPrev;
    csRise       = st.csSync[1] & ~st.csPrev;
    replyIdx     = (st.lastSel == SEL_FOUR);
    replyPayload = 10'h000;
    replyBody    = 15'h0000;
    frameOk      = 1'b0;
    rxSel        = SEL_NONE;
    rxIdx        = 1'b0;

    next_st.sckSync  = {st.sckSync[0], spi.sck};
    next_st.csSync   = {st.csSync[0], spi.csN};
    next_st.mosiSync = {st.mosiSync[0], spi.mosi};
    next_st.sckPrev  = st.sckSync[1];
    next_st.csPrev   = st.csSync[1];
    next_st.update   = 2'b00;

    // Readback source depends on the shared mode bits of the pair
    case ({pairBRegulationOff, readbackSourceSelect})
      2'b00: begin
        replyPayload = st.target[replyIdx];
      end
      2'b01: begin
        replyPayload = {appliedDuty[replyIdx], 2'b00};
      end
      2'b10: begin
        replyPayload = {st.duty[replyIdx], 2'b00};
      end
      2'b11: begin
        replyPayload = measured[replyIdx];
      end
      default: begin
        replyPayload = 10'h000;
      end
    endcase

    // Unknown previous message: only the parity error flag is reported
    if (st.lastSel != SEL_NONE) begin
      replyBody[POS_OC]             = faults[replyIdx][3];
      replyBody[POS_OL]             = faults[replyIdx][2];
      replyBody[POS_OT]             = faults[replyIdx][1];
      replyBody[POS_VDS]            = faults[replyIdx][0];
      replyBody[PAY_HI:0]           = replyPayload;
    end
    replyBody[POS_FMSG - 1 + 1]     = st.parityError;

    if (csFall) begin
      // Fault flags are sampled once per frame so the reply stays coherent
      next_st.txShift = {vdp_parity(replyBody), replyBody};
      next_st.bitCnt  = '0;
    end else if (!st.csSync[1]) begin
      if (sckRise && (st.bitCnt != FRAME_CNT)) begin
        next_st.rxShift = {st.rxShift[FRAME_BITS-2:0], st.mosiSync[1]};
        next_st.bitCnt  = st.bitCnt + CNT_W'(1);
      end
      if (sckFall) begin
        next_st.txShift = {st.txShift[FRAME_BITS-2:0], 1'b0};
      end
    end

    if (csRise) begin
      // A short frame counts as a transmission error too; a long frame keeps its first 16 bits
      frameOk = (st.bitCnt == FRAME_CNT) &&
                (st.rxShift[POS_PARITY] == vdp_parity(st.rxShift[14:0]));
      rxSel   = vdp_decode(st.rxShift[SEL_HI:SEL_LO]);
      rxIdx   = (rxSel == SEL_FOUR);
      next_st.parityError = ~frameOk;
      next_st.lastSel     = frameOk ? rxSel : SEL_NONE;
      // Bad frames never touch the set points: a corrupted command must not drive a valve
      if (frameOk && (rxSel != SEL_NONE)) begin
        if (pairBRegulationOff) begin
          next_st.duty[rxIdx]   = st.rxShift[PAY_HI:DUTY_LO];
        end else begin
          next_st.target[rxIdx] = st.rxShift[PAY_HI:0];
        end
        next_st.update[rxIdx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st         <= '0;
      st.csSync  <= 2'b11;
      st.csPrev  <= 1'b1;
      st.sckSync <= 2'b00;
      st.lastSel <= SEL_NONE;
    end else begin
      st <= next_st;
    end
  end

  // Drives only inside a frame so another device may share the line
  assign spi.miso              = st.txShift[FRAME_BITS-1];
  assign spi.misoOe            = ~st.csSync[1];
  assign drvThreeCurrentTarget = st.target[0];
  assign drvFourCurrentTarget  = st.target[1];
  assign drvThreeDuty          = st.duty[0];
  assign drvFourDuty           = st.duty[1];
  assign drvThreeUpdate        = st.update[0];
  assign drvFourUpdate         = st.update[1];
  assign parityErrorSeen       = st.parityError;

endmodule : vdp_device_end
`default_nettype wire

// ### src/vdp_host_ctrl.sv
// Purpose: Host end: SPI master sending valve driver messages from a register port
// Assumes: Link clock made here by dividing clk_sys; miso synchronised
// Notes:   Host must itself keep duty values within the legal duty ranges
`timescale 1ns/1ns
`default_nettype none
module vdp_host_ctrl
  import vdp_pkg::*;
#(
  parameter int HALF_CYCLES = 8                        // clk_sys cycles per link half period
)(
  input  wire logic        clk_sys,                    // System clock
  input  wire logic        rst_n,                      // Sync reset, active low
  vdp_spi_if.host          spi,                        // SPI link
  input  wire logic [3:0]  regAddr,                    // Register index
  input  wire logic [15:0] regWdata,                   // Write data
  input  wire logic        regWe,                      // Write strobe
  input  wire logic        regRe,                      // Read strobe
  output logic      [15:0] regRdata,                   // Read data, cycle after strobe
  output logic             irq                         // Level interrupt
);

  // Device needs about four cycles per link edge for its synchroniser
  if (HALF_CYCLES < 6 || HALF_CYCLES > 255) begin : g_chk
    $error("HALF_CYCLES must be 6..255");
  end

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYCLES - 1);

  typedef struct packed {
    vdp_hstate_e           state;
    logic [7:0]            divCnt;
    logic [CNT_W-1:0]      bitCnt;
    logic [FRAME_BITS-1:0] txShift;
    logic [FRAME_BITS-1:0] txLast;
    logic [FRAME_BITS-1:0] rxShift;
    logic [FRAME_BITS-1:0] rxData;
    logic [1:0]            misoSync;
    logic                  badParity;
    logic [IRQ_W-1:0]      intStat;
    logic [IRQ_W-1:0]      intMask;
    logic                  sck;
    logic                  csN;
    logic [15:0]           rdata;
  } vdp_host_s;

  vdp_host_s        st;
  vdp_host_s        next_st;
  logic             halfDone;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clearBits;
  logic [14:0]      body;

  always_comb begin
    next_st   = st;
    halfDone  = (st.divCnt == HALF_M1);
    events    = '0;
    body      = regWdata[14:0];
    clearBits = (regWe && regAddr == REG_INTSTAT) ? regWdata[IRQ_W-1:0] : '0;
    next_st.misoSync = {st.misoSync[0], spi.misoLine};
    next_st.divCnt   = halfDone ? 8'h00 : st.divCnt + 8'h01;

    case (st.state)
      H_IDLE: begin
        next_st.divCnt = 8'h00;
        if (regWe && regAddr == REG_TX) begin
          // Forced bad parity lets software check the error report
          next_st.txShift = {vdp_parity(body) ^ st.badParity, body};
          next_st.txLast  = {vdp_parity(body) ^ st.badParity, body};
          next_st.bitCnt  = '0;
          next_st.csN     = 1'b0;
          next_st.state   = H_SETUP;
        end
      end
      H_SETUP: begin
        if (halfDone) begin
          next_st.sck   = 1'b1;
          next_st.state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (halfDone) begin
          next_st.rxShift = {st.rxShift[FRAME_BITS-2:0], st.misoSync[1]};
          next_st.bitCnt  = st.bitCnt + CNT_W'(1);
          next_st.sck     = 1'b0;
          next_st.txShift = {st.txShift[FRAME_BITS-2:0], 1'b0};
          next_st.state   = H_LOW;
        end
      end
      H_LOW: begin
        if (halfDone) begin
          if (st.bitCnt == FRAME_CNT) begin
            next_st.csN   = 1'b1;
            next_st.state = H_GAP;
          end else begin
            next_st.sck   = 1'b1;
            next_st.state = H_HIGH;
          end
        end
      end
      H_GAP: begin
        if (halfDone) begin
          next_st.rxData       = st.rxShift;
          events[IRQ_DONE]     = 1'b1;
          events[IRQ_FMSG]     = st.rxShift[POS_FMSG];
          events[IRQ_FAULT]    = |st.rxShift[POS_OC:POS_OT];
          events[IRQ_BADRESP]  = st.rxShift[POS_PARITY] != vdp_parity(st.rxShift[14:0]);
          next_st.state        = H_IDLE;
        end
      end
      default: begin
        next_st.state = H_IDLE;
      end
    endcase

    // Set wins over a simultaneous write-one-to-clear
    next_st.intStat = (st.intStat & ~clearBits) | events;
    if (regWe && regAddr == REG_INTMASK) begin
      next_st.intMask = regWdata[IRQ_W-1:0];
    end
    if (regWe && regAddr == REG_CTRL) begin
      next_st.badParity = regWdata[CTRL_BADPAR];
    end

    next_st.rdata = 16'h0000;
    if (regRe) begin
      case (regAddr)
        REG_TX:      next_st.rdata = st.txLast;
        REG_RX:      next_st.rdata = st.rxData;
        REG_STATUS:  next_st.rdata = {15'h0000, st.state != H_IDLE};
        REG_CTRL:    next_st.rdata = {15'h0000, st.badParity};
        REG_INTSTAT: next_st.rdata = {12'h000, st.intStat};
        REG_INTMASK: next_st.rdata = {12'h000, st.intMask};
        default:     next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st       <= '0;
      st.state <= H_IDLE;
      st.csN   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign spi.sck  = st.sck;
  assign spi.csN  = st.csN;
  assign spi.mosi = st.txShift[FRAME_BITS-1];
  assign regRdata = st.rdata;
  assign irq      = |(st.intStat & st.intMask);

endmodule : vdp_host_ctrl
`default_nettype wire

// ### dv/vdp_link_sva.sv
// Purpose: Link checks between host end and device end
// Assumes: HALF_CYCLES of 6 in the bench, odd parity on both lines
// Notes:   Helper logic rebuilds each frame from the wire itself
`timescale 1ns/1ns
`default_nettype none
module vdp_link_sva
  import vdp_pkg::*;
(
  input wire logic clk_sys,  // System clock
  input wire logic rst_n,    // Sync reset, active low
  input wire logic sck,      // Link clock
  input wire logic csN,      // Frame select, active low
  input wire logic mosi,     // Host data
  input wire logic miso,     // Device data
  input wire logic misoOe,   // Device drive enable
  input wire logic misoLine  // Resolved device data
);
  logic        sckQ;
  logic        csQ;
  logic [4:0]  riseCnt;
  logic [15:0] inWord;
  logic [15:0] outWord;
  logic        prevBad;
  logic        prevDrv;
  logic        nowBad;

  // A short frame counts as bad, like a parity slip
  assign nowBad = (riseCnt != 5'h10) || !(^inWord);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sckQ    <= 1'b0;
      csQ     <= 1'b1;
      riseCnt <= 5'h00;
      inWord  <= 16'h0000;
      outWord <= 16'h0000;
      prevBad <= 1'b0;
      prevDrv <= 1'b0;
    end else begin
      sckQ <= sck;
      csQ  <= csN;
      if (sck && !sckQ) begin
        riseCnt <= riseCnt + 5'h01;
        inWord  <= {inWord[14:0], mosi};
        outWord <= {outWord[14:0], misoLine};
      end
      if (csN && !csQ) begin
        riseCnt <= 5'h00;
        prevBad <= nowBad;
        prevDrv <= !nowBad && (inWord[14:10] == MSG_DRV_THREE || inWord[14:10] == MSG_DRV_FOUR);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence frameEnd;
    $rose(csN);
  endsequence
  sequence frameStart;
    $fell(csN);
  endsequence

  sck_idle_a: assert property (csN |-> !sck) else $error("link clock runs outside frame");
  frame_gap_a: assert property (frameEnd |-> csN[*6]) else $error("frame gap too short");
  half_period_a: assert property ($rose(sck) |-> sck[*6]) else $error("clock high phase short");
  mosi_hold_a: assert property (sck |-> $stable(mosi)) else $error("host data moved while high");
  miso_hold_a: assert property (sck && misoOe |-> $stable(miso)) else $error("reply moved while high");
  oe_on_a: assert property (frameStart |-> ##[1:4] misoOe) else $error("reply not driven");
  oe_off_a: assert property (frameEnd |-> ##[1:4] !misoOe) else $error("reply line not released");
  bit_count_a: assert property (frameEnd |-> riseCnt == 5'h10)
    else $error("frame not sixteen bits");
  reply_parity_a: assert property (frameEnd |-> ^outWord)
    else $error("reply parity wrong");
  reply_flag_a: assert property (frameEnd |-> outWord[14] == prevBad)
    else $error("reply error flag wrong");
  reply_quiet_a: assert property (frameEnd ##0 !prevDrv |-> outWord[13:0] == 14'h0000)
    else $error("reply carries data for no driver");
endmodule : vdp_link_sva
`default_nettype wire

// ### dv/tb_valve_driver_pair_spi_messages.sv
// Purpose: Frames through host end and device end against a bench model
// Assumes: Device inputs held steady while a frame is in flight
// Notes:   Each reply is predicted from the previous frame and live inputs
`timescale 1ns/1ns
`default_nettype none
module tb_valve_driver_pair_spi_messages;
  import vdp_pkg::*;
  logic        clk_sys, rst_n, regWe, regRe, irq, off, src, up3, up4, perr;
  logic [3:0]  regAddr, flg3, flg4;
  logic [15:0] regWdata, regRdata, rnd, d, e;
  logic [7:0]  ad3, ad4, dt3, dt4, duty;
  logic [9:0]  mc3, mc4, tg3, tg4;
  logic [9:0]  mTg [2];
  logic [7:0]  mDt [2];
  logic [4:0]  sel;
  logic [14:0] body;
  logic        bad;
  int          bad_count, total_checks, cyc, n3, n4, pSel, pBad, i;
  int          upd [2];

  vdp_spi_if i_vdp_spi_if ();
  vdp_device_end i_vdp_device_end (.clk_sys(clk_sys), .rst_n(rst_n), .spi(i_vdp_spi_if),
    .pairBRegulationOff(off), .readbackSourceSelect(src), .drvThreeOvercurrent(flg3[3]),
    .drvThreeOpenLoad(flg3[2]), .drvThreeOvertemp(flg3[1]), .drvThreeDrainVoltageSeen(flg3[0]),
    .drvFourOvercurrent(flg4[3]), .drvFourOpenLoad(flg4[2]), .drvFourOvertemp(flg4[1]),
    .drvFourDrainVoltageSeen(flg4[0]), .drvThreeAppliedDuty(ad3), .drvFourAppliedDuty(ad4),
    .drvThreeMeasuredCurrent(mc3), .drvFourMeasuredCurrent(mc4), .drvThreeCurrentTarget(tg3),
    .drvFourCurrentTarget(tg4), .drvThreeDuty(dt3), .drvFourDuty(dt4), .drvThreeUpdate(up3),
    .drvFourUpdate(up4), .parityErrorSeen(perr));
  vdp_host_ctrl #(.HALF_CYCLES(6)) i_vdp_host_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .spi(i_vdp_spi_if), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata), .irq(irq));
  vdp_link_sva i_vdp_link_sva (.clk_sys(clk_sys), .rst_n(rst_n), .sck(i_vdp_spi_if.sck),
    .csN(i_vdp_spi_if.csN), .mosi(i_vdp_spi_if.mosi), .miso(i_vdp_spi_if.miso),
    .misoOe(i_vdp_spi_if.misoOe), .misoLine(i_vdp_spi_if.misoLine));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Reply for the driver of the previous frame, mode bits read live
  function automatic logic [15:0] expReply();
    logic [14:0] b;
    b = 15'h0000;
    b[14] = pBad[0];
    if (pSel >= 0) begin
      b[13:10] = pSel ? flg4 : flg3;
      case ({off, src})
        2'b00: b[9:0] = mTg[pSel];
        2'b01: b[9:0] = {pSel ? ad4 : ad3, 2'b00};
        2'b10: b[9:0] = {mDt[pSel], 2'b00};
        default: b[9:0] = pSel ? mc4 : mc3;
      endcase
    end
    return {~^b, b};
  endfunction : expReply

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= w;
    regWe    <= 1'b1;
    @(posedge clk_sys);
    regWe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge clk_sys);
    regAddr <= a;
    regRe   <= 1'b1;
    @(posedge clk_sys);
    regRe <= 1'b0;
    #1 r = regRdata;
  endtask : rd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (up3 === 1'b1) n3++;
    if (up4 === 1'b1) n4++;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    {rst_n, regWe, regRe, off, src, flg3, flg4, ad3, ad4, mc3, mc4} = '0;
    {regAddr, regWdata} = '0;
    {mTg[0], mTg[1], mDt[0], mDt[1]} = '0;
    rnd = 16'hA119;
    pSel = -1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'hF, d);
    chk("unmapped", 16'h0000, d);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      rnd = lfsr(rnd);
      off <= k[1];
      src <= k[2];
      flg3 <= rnd[3:0];
      flg4 <= rnd[7:4];
      ad3 <= rnd[15:8];
      ad4 <= rnd[11:4];
      rnd = lfsr(rnd);
      mc3 <= rnd[9:0];
      mc4 <= {rnd[3:0], rnd[15:10]};
      sel = rnd[14:10];
      if (sel == MSG_DRV_THREE || sel == MSG_DRV_FOUR) sel = sel ^ 5'h10;
      if (k % 4 == 0 || k % 4 == 2) sel = MSG_DRV_THREE;
      if (k % 4 == 1 || k % 8 == 7) sel = MSG_DRV_FOUR;
      duty = (rnd % 3 == 0) ? 8'h00 : (rnd % 3 == 1) ? 8'hFF : 8'(26 + rnd % 204);
      body = {sel, k[1] ? {duty, rnd[1:0]} : rnd[9:0]};
      bad = (k % 5 == 4);
      wr(REG_CTRL, {15'h0000, bad});
      wr(REG_INTMASK, {15'h0000, k[0]});
      wr(REG_TX, {1'b0, body});
      // A second order while busy must be dropped; the sent word check proves it
      if (k % 8 == 3) wr(REG_TX, 16'h7FFF);
      for (i = 0; i < 300; i++) begin
        rd(REG_STATUS, d);
        if (d[ST_BUSY] === 1'b0) break;
      end
      // A poll that runs out counts as a mismatch
      chk("idle after frame", 16'h0000, {15'h0000, d[ST_BUSY]});
      e = expReply();
      rd(REG_RX, d);
      chk("reply", e, d);
      rd(REG_TX, d);
      chk("sent word", {~^body ^ bad, body}, d);
      rd(REG_INTSTAT, d);
      chk("events", {13'h0000, |e[13:11], e[14], 1'b1}, d);
      chk("irq", {15'h0000, k[0]}, {15'h0000, irq});
      wr(REG_INTSTAT, 16'h000F);
      rd(REG_INTSTAT, d);
      chk("events cleared", 16'h0000, d);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      pBad = bad;
      pSel = bad ? -1 : (sel == MSG_DRV_THREE) ? 0 : (sel == MSG_DRV_FOUR) ? 1 : -1;
      if (pSel >= 0) begin
        if (k[1]) mDt[pSel] = body[9:2];
        else mTg[pSel] = body[9:0];
        upd[pSel]++;
      end
      chk("target three", 16'(mTg[0]), 16'(tg3));
      chk("target four", 16'(mTg[1]), 16'(tg4));
      chk("duty three", 16'(mDt[0]), 16'(dt3));
      chk("duty four", 16'(mDt[1]), 16'(dt4));
      chk("updates three", 16'(upd[0]), 16'(n3));
      chk("updates four", 16'(upd[1]), 16'(n4));
      chk("parity error", {15'h0000, bad}, {15'h0000, perr});
      $display("frame %0d done", k);
    end
    complete_run();
  end
endmodule : tb_valve_driver_pair_spi_messages
`default_nettype wire
